// ==== core/mwc_pkg.sv ====
// constants and types of the motion watch configuration block
// Notes on behaviour
// - low four bits pick watch sample rate
// - upper three bits pick standby clock rate
// - pointer 0x0f applies, 0x02 enters watch
// - other rate codes need plain write only
// - axis event when delta exceeds threshold
// - per-axis thresholds and false-detection counts
// - count field holds events minus one
// - threshold field maps to six shadows
// - select 000 none, 001 x threshold
// - axis flags combined by and or or
// - previous mode: delta against last sample
// - baseline mode: delta against first sample
// - bit7 reference, bit6 combine, bits5:0 shadow
// - thresholds act only in watch mode
`default_nettype none
package mwc_pkg;
  // ****************
  // register offsets
  // ****************
  localparam logic [7:0] mwc_off_mode   = 8'h10;
  localparam logic [7:0] mwc_off_ptr    = 8'h11;
  localparam logic [7:0] mwc_off_rate   = 8'h12;
  localparam logic [7:0] mwc_off_thresh = 8'h13;
  localparam logic [7:0] mwc_off_sel    = 8'h14;
  localparam logic [7:0] mwc_off_pwr    = 8'h1c;
  localparam logic [7:0] mwc_off_data   = 8'h29;
  // ****************
  // values and fields
  // ****************
  localparam logic [7:0] mwc_mode_watch = 8'h02;
  localparam logic [7:0] mwc_ptr_apply  = 8'h0f;
  localparam logic [7:0] mwc_ptr_a0     = 8'h10;
  localparam logic [7:0] mwc_ptr_a1     = 8'h30;
  localparam logic [7:0] mwc_ptr_a2     = 8'h60;
  localparam logic [7:0] mwc_ptr_a3     = 8'h70;
  localparam logic [3:0] mwc_rate_fast  = 4'hf;
  localparam logic [7:0] mwc_reg_reset  = 8'h00;
  localparam int         mwc_ref_bit    = 7;
  localparam int         mwc_comb_bit   = 6;
  localparam int         mwc_pwr_lo     = 4;
  // shadow select codes
  localparam logic [2:0] mwc_sh_none    = 3'h0;
  localparam logic [2:0] mwc_sh_thx     = 3'h1;
  localparam logic [2:0] mwc_sh_cntx    = 3'h5;
  localparam int         mwc_axes       = 3;
  localparam int         mwc_sw         = 12;
  // one sample of all three axes
  typedef struct packed {
    logic signed [mwc_sw-1:0] z;
    logic signed [mwc_sw-1:0] y;
    logic signed [mwc_sw-1:0] x;
  } mwc_sample_t;
endpackage : mwc_pkg
`default_nettype wire

// ==== core/mwc_watch.sv ====
// register file and activity detection of the motion watch block
`default_nettype none
module mwc_watch
  import mwc_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // register port
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata,
  // sample stream
  input  wire logic        sample_valid,
  input  wire mwc_sample_t sample,
  // state towards the rest of the device
  output logic      [3:0]  watch_rate_select,
  output logic      [2:0]  standby_clock_rate,
  output logic      [2:0]  power_mode,
  output logic             watch_active,
  output logic             rate15_ready,
  output logic      [2:0]  axis_flag,
  output logic             watch_wakeup
);
  // ****************
  // registers
  // ****************
  logic [7:0] rate_reg;
  logic [7:0] thr_ctl;
  logic [2:0] shadow_sel;
  logic [7:0] ptr_reg;
  logic [3:0] r15_seen;
  logic [5:0] thr [mwc_axes];
  logic [5:0] cnt [mwc_axes];
  logic       entry;
  logic       comb_now;
  logic       comb_last;

  // shadow index of an axis, or -1 style miss
  function automatic logic [1:0] axis_of(input logic [2:0] s);
    axis_of = (s >= mwc_sh_cntx) ? 2'(s - mwc_sh_cntx) : 2'(s - mwc_sh_thx);
  endfunction : axis_of

  wire wr_rate = wr_en && addr == mwc_off_rate;
  wire wr_thr  = wr_en && addr == mwc_off_thresh;
  wire wr_mode = wr_en && addr == mwc_off_mode;
  wire wr_ptr  = wr_en && addr == mwc_off_ptr;
  wire sh_thr  = shadow_sel >= mwc_sh_thx && shadow_sel < 3'h4;
  wire sh_cnt  = shadow_sel >= mwc_sh_cntx;

  // rate control; bit 4 is stored as zero whatever the host sends
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rate_reg <= mwc_reg_reset;
    end else if (wr_rate) begin
      rate_reg <= {wdata[7:5], 1'b0, wdata[3:0]};
    end
  end

  // threshold control, selector and power mode
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      thr_ctl    <= mwc_reg_reset;
      shadow_sel <= mwc_sh_none;
      power_mode <= '0;
    end else if (wr_thr) begin
      thr_ctl <= wdata;
    end else if (wr_en && addr == mwc_off_sel) begin
      shadow_sel <= wdata[2:0];
    end else if (wr_en && addr == mwc_off_pwr) begin
      power_mode <= wdata[mwc_pwr_lo+2:mwc_pwr_lo];
    end
  end

  // shadow registers behind the threshold field; select 000 and 100 hit nothing
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < mwc_axes; i++) begin
        thr[i] <= '0;
        cnt[i] <= '0;
      end
    end else if (wr_thr && sh_thr) begin
      thr[axis_of(shadow_sel)] <= wdata[5:0];
    end else if (wr_thr && sh_cnt) begin
      cnt[axis_of(shadow_sel)] <= wdata[5:0];
    end
  end

  // unlock tracking for the fastest rate: four setup writes, then apply
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ptr_reg      <= '0;
      r15_seen     <= '0;
      rate15_ready <= 1'b0;
    end else begin
      if (wr_ptr) begin
        ptr_reg <= wdata;
      end
      if (wr_ptr && wdata == mwc_ptr_apply) begin
        rate15_ready <= &r15_seen;
      end
      if (wr_en && addr == mwc_off_data) begin
        if (ptr_reg == mwc_ptr_a0) r15_seen[0] <= 1'b1;
        if (ptr_reg == mwc_ptr_a1) r15_seen[1] <= 1'b1;
        if (ptr_reg == mwc_ptr_a2) r15_seen[2] <= 1'b1;
        if (ptr_reg == mwc_ptr_a3) r15_seen[3] <= 1'b1;
      end
    end
  end

  // mode: only the watch code enters watch, anything else leaves it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      watch_active <= 1'b0;
      entry        <= 1'b0;
    end else begin
      entry <= wr_mode && wdata == mwc_mode_watch && !watch_active;
      if (wr_mode) begin
        watch_active <= wdata == mwc_mode_watch;
      end
    end
  end

  // rate outputs; the fastest code falls back to 0000 until unlocked
  always_comb begin
    standby_clock_rate = rate_reg[7:5];
    if (rate_reg[3:0] != mwc_rate_fast || rate15_ready) begin
      watch_rate_select = rate_reg[3:0];
    end else begin
      watch_rate_select = '0;
    end
  end

  // ****************
  // per-axis detection
  // ****************
  logic signed [mwc_sw-1:0] cur [mwc_axes];
  assign cur[0] = sample.x;
  assign cur[1] = sample.y;
  assign cur[2] = sample.z;
  logic       have_ref;
  logic [2:0] hit;

  for (genvar a = 0; a < mwc_axes; a++) begin : g_axis
    logic signed [mwc_sw-1:0] ref_s;
    logic signed [mwc_sw:0]   diff;
    logic        [mwc_sw:0]   delta;
    logic        [5:0]        events;
    assign diff  = (mwc_sw+1)'(cur[a]) - (mwc_sw+1)'(ref_s);
    assign delta = diff[mwc_sw] ? (mwc_sw+1)'(-diff) : diff;
    assign hit[a] = delta > (mwc_sw+1)'(thr[a]);

    // reference: moving in previous mode, frozen after first sample in baseline mode
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        ref_s <= '0;
      end else if (watch_active && sample_valid) begin
        if (!have_ref || !thr_ctl[mwc_ref_bit]) begin
          ref_s <= cur[a];
        end
      end
    end

    // false-detection count; flag holds until watch is re-entered
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        events      <= '0;
        axis_flag[a] <= 1'b0;
      end else if (entry) begin
        events      <= '0;
        axis_flag[a] <= 1'b0;
      end else if (watch_active && sample_valid && have_ref && hit[a]) begin
        if (events == cnt[a]) begin
          axis_flag[a] <= 1'b1;
        end else begin
          events <= events + 6'h01;
        end
      end
    end
  end

  // first sample after entry only seeds the reference
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      have_ref <= 1'b0;
    end else if (entry || !watch_active) begin
      have_ref <= 1'b0;
    end else if (sample_valid) begin
      have_ref <= 1'b1;
    end
  end

  // combine axes; the wakeup pulses once as the combination becomes true
  assign comb_now = thr_ctl[mwc_comb_bit] ? &axis_flag : |axis_flag;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      comb_last    <= 1'b0;
      watch_wakeup <= 1'b0;
    end else begin
      comb_last    <= comb_now;
      watch_wakeup <= comb_now && !comb_last && watch_active;
    end
  end

  // read data, registered; shadow reads follow the selector
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (rd_en) begin
      if (addr == mwc_off_rate) begin
        rdata <= rate_reg;
      end else if (addr == mwc_off_thresh) begin
        rdata <= {thr_ctl[7:6], sh_thr ? thr[axis_of(shadow_sel)]
                 : sh_cnt ? cnt[axis_of(shadow_sel)] : 6'h00};
      end else if (addr == mwc_off_sel) begin
        rdata <= {5'h00, shadow_sel};
      end else if (addr == mwc_off_ptr) begin
        rdata <= ptr_reg;
      end else begin
        rdata <= '0;
      end
    end
  end

  // ****************
  // checks
  // ****************
  // register bank and unlock
  a_bit4_zero: assert property (@(posedge clock) disable iff (rst) rate_reg[4] == 1'b0)
    else $error("rate register bit 4 not zero");
  a_fast_locked: assert property (@(posedge clock) disable iff (rst)
    rate_reg[3:0] == mwc_rate_fast && !rate15_ready |-> watch_rate_select == 4'h0)
    else $error("fast rate used before unlock");
  a_plain_rate: assert property (@(posedge clock) disable iff (rst)
    wr_rate && wdata[3:0] != mwc_rate_fast |=> watch_rate_select == $past(wdata[3:0]))
    else $error("plain rate write not applied");
  a_stby_rate: assert property (@(posedge clock) disable iff (rst)
    wr_rate |=> standby_clock_rate == $past(wdata[7:5]))
    else $error("standby rate not applied");
  a_ready_apply: assert property (@(posedge clock) disable iff (rst)
    wr_ptr && wdata == mwc_ptr_apply |=> rate15_ready == $past(&r15_seen))
    else $error("apply did not follow the setup writes");
  a_mode_write: assert property (@(posedge clock) disable iff (rst)
    wr_mode |=> watch_active == ($past(wdata) == mwc_mode_watch))
    else $error("mode write not applied");
  a_ctl_write: assert property (@(posedge clock) disable iff (rst)
    wr_thr ##1 !wr_en ##1 rd_en && addr == mwc_off_thresh && !wr_en |=> rdata[7:6] == $past(wdata[7:6], 3))
    else $error("threshold control bits lost");
  a_x_thresh: assert property (@(posedge clock) disable iff (rst)
    wr_thr && shadow_sel == mwc_sh_thx |=> thr[0] == $past(wdata[5:0]))
    else $error("x threshold not written");
  a_y_thresh: assert property (@(posedge clock) disable iff (rst)
    wr_thr && shadow_sel == mwc_sh_thx + 3'h1 |=> thr[1] == $past(wdata[5:0]))
    else $error("y threshold not written");
  a_cntx_write: assert property (@(posedge clock) disable iff (rst)
    wr_thr && shadow_sel == mwc_sh_cntx |=> cnt[0] == $past(wdata[5:0]))
    else $error("x count not written");
  a_none_hold: assert property (@(posedge clock) disable iff (rst)
    wr_thr && shadow_sel == mwc_sh_none |=>
    thr[0] == $past(thr[0]) && thr[1] == $past(thr[1]) && thr[2] == $past(thr[2]))
    else $error("select none changed a threshold");
  a_sel_read: assert property (@(posedge clock) disable iff (rst)
    rd_en && addr == mwc_off_thresh && shadow_sel == mwc_sh_thx |=> rdata[5:0] == $past(thr[0]))
    else $error("shadow read not the selected one");

  // detection and wakeup; axis x stands in for y and z, which share its generated code
  a_flag_idle: assert property (@(posedge clock) disable iff (rst)
    entry |=> axis_flag == 3'h0)
    else $error("flags survive watch entry");
  a_entry_clear: assert property (@(posedge clock) disable iff (rst)
    entry |=> g_axis[0].events == 6'h00)
    else $error("event count survives watch entry");
  a_idle_hold: assert property (@(posedge clock) disable iff (rst)
    !watch_active |=> axis_flag == $past(axis_flag))
    else $error("flags moved outside watch mode");
  a_seed_only: assert property (@(posedge clock) disable iff (rst)
    sample_valid && !have_ref && !entry |=> axis_flag == $past(axis_flag))
    else $error("seed sample raised a flag");
  a_miss_hold: assert property (@(posedge clock) disable iff (rst)
    !entry && !hit[0] |=> axis_flag[0] == $past(axis_flag[0]))
    else $error("x flag moved without a hit");
  a_hit_set: assert property (@(posedge clock) disable iff (rst)
    watch_active && sample_valid && have_ref && !entry && hit[0] && g_axis[0].events == cnt[0] |=> axis_flag[0])
    else $error("x flag not raised at full count");
  a_prev_ref: assert property (@(posedge clock) disable iff (rst)
    watch_active && sample_valid && !thr_ctl[mwc_ref_bit] |=> g_axis[0].ref_s == $past(cur[0]))
    else $error("previous sample not kept as reference");
  a_base_hold: assert property (@(posedge clock) disable iff (rst)
    watch_active && sample_valid && have_ref && thr_ctl[mwc_ref_bit] |=> g_axis[0].ref_s == $past(g_axis[0].ref_s))
    else $error("baseline moved");
  a_and_mode: assert property (@(posedge clock) disable iff (rst)
    watch_wakeup && thr_ctl[mwc_comb_bit] && !$past(wr_thr) |-> $past(&axis_flag))
    else $error("and combine fired early");
  a_or_mode: assert property (@(posedge clock) disable iff (rst)
    watch_wakeup && !thr_ctl[mwc_comb_bit] && !$past(wr_thr) |-> $past(|axis_flag))
    else $error("or combine fired with no flag");
  a_wake_pulse: assert property (@(posedge clock) disable iff (rst)
    watch_wakeup |=> !watch_wakeup)
    else $error("wakeup longer than one cycle");
  a_wake_mode: assert property (@(posedge clock) disable iff (rst)
    watch_wakeup |-> $past(watch_active))
    else $error("wakeup outside watch mode");
endmodule : mwc_watch
`default_nettype wire

// ==== bench/mwc_host.sv ====
// host controller model driving the register port of the watch block
`default_nettype none
module mwc_host
  import mwc_pkg::*;
(
  // clock
  input  wire logic       clock,
  // register port
  output logic            wr_en,
  output logic            rd_en,
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  input  wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // rate 15 unlock as offset/value pairs, ultra low power column
  localparam logic [15:0] steps [14] = '{16'h1001, 16'h1504, 16'h165d, 16'h1c30, 16'h1110, 16'h2930, 16'h1130,
    16'h2901, 16'h1160, 16'h2952, 16'h1170, 16'h2901, 16'h110f, 16'h1002};
  // idle bus at time zero
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr  = 8'h00;
    wdata = 8'h00;
  end
  // one write; bit 4 of the rate register is cleared here so no caller can set it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock) #1;
    wr_en = 1'b1;
    addr  = a;
    wdata = (a == mwc_off_rate) ? (d & 8'hef) : d;
    @(posedge clock) #1;
    wr_en = 1'b0;
    addr  = ~addr;
    wdata = ~wdata;
  endtask : wr
  // one read, data taken one edge after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock) #1;
    rd_en = 1'b1;
    addr  = a;
    @(posedge clock) #1;
    rd_en = 1'b0;
    addr  = ~addr;
    d     = rdata;
  endtask : rd
  // full unlock walk, ends by entering watch mode
  task automatic unlock();
    for (int i = 0; i < 14; i++) begin
      wr(steps[i][15:8], steps[i][7:0]);
    end
  endtask : unlock
endmodule : mwc_host
`default_nettype wire

// ==== bench/motion_watch_config_tb.sv ====
// self-checking testbench of the motion watch block
`default_nettype none
module motion_watch_config_tb
  import mwc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************
  // signals
  // ****************
  logic        clock = 1'b0;
  logic        rst   = 1'b1;
  logic        wr_en, rd_en, sample_valid, watch_active, rate15_ready, watch_wakeup, seen;
  logic [7:0]  addr, wdata, rdata, rv, v;
  mwc_sample_t sample;
  logic [3:0]  watch_rate_select;
  logic [2:0]  standby_clock_rate, power_mode, axis_flag;
  int          bad_count = 0;
  int          n_tests   = 0;
  // free running clock
  always #5 clock = ~clock;
  mwc_host host_u (.clock(clock), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata));
  mwc_watch dut_u (.clock(clock), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
    .rdata(rdata), .sample_valid(sample_valid), .sample(sample), .watch_rate_select(watch_rate_select),
    .standby_clock_rate(standby_clock_rate), .power_mode(power_mode), .watch_active(watch_active),
    .rate15_ready(rate15_ready), .axis_flag(axis_flag), .watch_wakeup(watch_wakeup));
  // ****************
  // helpers
  // ****************
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  // stored rate byte never keeps bit 4
  function automatic logic [7:0] rate_exp(input logic [7:0] w);
    return w & 8'hef;
  endfunction : rate_exp
  // pick a shadow, then write the threshold byte
  task automatic cfg(input logic [2:0] s, input logic [7:0] d);
    host_u.wr(mwc_off_sel, {5'h00, s});
    host_u.wr(mwc_off_thresh, d);
  endtask : cfg
  // standby then watch, so the entry always counts as fresh
  task automatic enter();
    host_u.wr(mwc_off_mode, 8'h01);
    host_u.wr(mwc_off_mode, mwc_mode_watch);
    repeat (2) @(posedge clock);
  endtask : enter
  // one sample pulse, then flags and any wakeup pulse over three cycles
  task automatic send(input int x, input int y, input int z, input logic [2:0] fl, input logic wk);
    @(posedge clock) #1;
    sample_valid = 1'b1;
    sample       = {z[11:0], y[11:0], x[11:0]};
    @(posedge clock) #1;
    sample_valid = 1'b0;
    sample       = ~sample;
    seen         = 1'b0;
    repeat (3) begin
      @(posedge clock) #1;
      seen = seen | watch_wakeup;
    end
    check({5'h00, axis_flag}, {5'h00, fl}, "flags");
    check({7'h00, seen}, {7'h00, wk}, "wakeup");
  endtask : send
  // watchdog: a hang ends the run as a failure
  initial begin
    #500000;
    bad_count++;
    $display("mismatch at %0t: run did not finish", $time);
    summarize();
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    sample_valid = 1'b0;
    sample       = '0;
    void'($urandom(32'h7c31826a));
    repeat (8) @(posedge clock);
    #1 rst = 1'b0;
    host_u.rd(mwc_off_rate, rv);
    check(rv, 8'h00, "rate reset");
    host_u.rd(mwc_off_thresh, rv);
    check(rv, mwc_reg_reset, "thr reset");
    host_u.rd(8'h20, rv);
    check(rv, 8'h00, "unmapped");
    // plain rate writes, first one a corner with every field high
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'hfc : 8'($urandom);
      if (v[3:0] > 4'hc) begin
        v[3:0] = 4'h5;
      end
      host_u.wr(mwc_off_rate, v);
      check({4'h0, watch_rate_select}, {4'h0, v[3:0]}, "rate");
      check({5'h00, standby_clock_rate}, {5'h00, v[7:5]}, "standby");
      host_u.rd(mwc_off_rate, rv);
      check(rv, rate_exp(v), "rate read");
    end
    // fastest rate stays hidden until the unlock walk is applied
    host_u.wr(mwc_off_rate, 8'h0f);
    check({4'h0, watch_rate_select}, 8'h00, "locked");
    host_u.unlock();
    host_u.wr(mwc_off_rate, 8'h0f);
    check({4'h0, watch_rate_select}, 8'h0f, "unlocked");
    check({3'h0, power_mode, rate15_ready, watch_active}, 8'h0f, "mode");
    // shadow access: select none touches only the top bits
    v = 8'($urandom);
    cfg(mwc_sh_thx, v);
    host_u.rd(mwc_off_thresh, rv);
    check(rv, v, "x thr");
    cfg(mwc_sh_none, ~v);
    host_u.rd(mwc_off_thresh, rv);
    check(rv, {~v[7:6], 6'h00}, "none");
    host_u.wr(mwc_off_sel, 8'h01);
    host_u.rd(mwc_off_thresh, rv);
    check(rv, {~v[7:6], v[5:0]}, "x kept");
    // or, previous sample, x needs two hits
    cfg(3'h1, 8'h05);
    cfg(3'h2, 8'h3f);
    cfg(3'h3, 8'h3f);
    cfg(mwc_sh_cntx, 8'h01);
    host_u.wr(mwc_off_mode, 8'h01);
    send(0, 0, 0, 3'h0, 1'b0);
    send(40, 0, 0, 3'h0, 1'b0);
    enter();
    send(0, 0, 0, 3'h0, 1'b0);
    send(5, 0, 0, 3'h0, 1'b0);
    send(11, 0, 0, 3'h0, 1'b0);
    send(11, 0, 0, 3'h0, 1'b0);
    send(17, 0, 0, 3'h1, 1'b1);
    send(17, 100, 0, 3'h3, 1'b0);
    // and, baseline, single hits
    cfg(mwc_sh_cntx, 8'hc0);
    cfg(3'h1, 8'hc5);
    cfg(3'h2, 8'hc5);
    cfg(3'h3, 8'hc5);
    enter();
    send(0, 0, 0, 3'h0, 1'b0);
    send(3, 0, 0, 3'h0, 1'b0);
    send(7, 0, 0, 3'h1, 1'b0);
    send(7, -6, 0, 3'h3, 1'b0);
    send(7, -6, 6, 3'h7, 1'b1);
    summarize();
  end
endmodule : motion_watch_config_tb
`default_nettype wire
